/* File: core/epp_consts.svh */
// Register indices, field positions, reset values and read-back ones of the EPP handshake engine.
`ifndef EPP_CONSTS_SVH
`define EPP_CONSTS_SVH

`define IDX_DTR         4'h0
`define IDX_STR         4'h1
`define IDX_CTL         4'h2
`define IDX_ADDR        4'h3
`define IDX_DATA0       4'h4
`define IDX_DATA3       4'h7
`define IDX_PCR         4'h8
`define IDX_FCR         4'h9
`define IDX_PTR         4'ha

`define PCR_EPP_EN_BIT  0
`define PCR_REV19_BIT   1
`define FCR_ZWS_EN_BIT  5
`define FCR_ZWS_DIS_BIT 6
`define PTR_DIRCTL_BIT  7
`define CTL_STB_BIT     0
`define CTL_AFD_BIT     1
`define CTL_INIT_BIT    2
`define CTL_LEGACY_SELECTIN_LINE_BIT    3
`define CTL_DIR_BIT     5

`define CTL_RESET       8'h00
`define CTL_RD_ONES     8'hc0
`define PCR_RESET       8'h00
`define FCR_RESET       8'h00
`define PTR_RESET       8'h00
`define DTR_RESET       8'h00

`endif

/* File: core/epp_pkg.sv */
// Types shared by the EPP handshake engine.
package epp_pkg;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_W19_WAITLO,
        ST_R19_WAITLO,
        ST_STROBE19,
        ST_ACK,
        ST_END17,
        ST_TAIL19
    } epp_state_t;

    typedef struct packed {
        logic write_n;
        logic addr_strobe_n;
        logic data_strobe_n;
    } epp_ctl_lines_t;

endpackage

/* File: core/epp_handshake_engine.sv */
// EPP transfer engine: Avalon-MM register port turned into EPP handshake cycles.
`timescale 1ns/100ps
`include "epp_consts.svh"

module epp_handshake_engine
    import epp_pkg::*;
(
    input  wire logic        CLK_SYS,
    input  wire logic        RST,
    input  wire logic [5:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    output logic             IOCHRDY,
    output logic             ZERO_WAIT_GRANT_N,
    input  wire logic        WAIT_N,
    input  wire logic [7:0]  PERIPH_DATA_I,
    output logic      [7:0]  PERIPH_DATA_O,
    output logic             PERIPH_DATA_OE,
    output logic             LEGACY_STROBE_LINE_O,
    output logic             LEGACY_AUTOFEED_LINE_O,
    output logic             LEGACY_SELECTIN_LINE_O,
    output logic             INIT_LINE_O
);

    epp_state_t     state_q;
    epp_ctl_lines_t lines_q;
    logic           wait_m_q;
    logic           wait_s_q;
    logic [7:0]     pd_m_q;
    logic [7:0]     pd_s_q;
    logic [7:0]     pd_out_q;
    logic           pd_oe_q;
    logic [7:0]     rdata_q;
    logic [7:0]     port_ctl_reg_q;
    logic [7:0]     port_cfg_reg_q;
    logic [7:0]     func_cfg_reg_q;
    logic [7:0]     port_tweak_reg_q;
    logic           sel_addr_q;
    logic           is_read_q;
    logic           saw_low_q;
    logic           zws_q;
    logic [1:0]     dwell_q;
    logic [3:0]     idx;
    logic           epp_en;
    logic           rev19;
    logic           zws_en;
    logic           req;
    logic           epp_req;

    function automatic logic is_epp_idx(input logic [3:0] i);
        is_epp_idx = (i >= `IDX_ADDR) && (i <= `IDX_DATA3);
    endfunction

    assign idx     = AVS_ADDRESS[5:2];
    assign req     = AVS_READ | AVS_WRITE;
    assign epp_en  = port_cfg_reg_q[`PCR_EPP_EN_BIT];
    assign rev19   = port_cfg_reg_q[`PCR_REV19_BIT] & epp_en;
    assign zws_en  = func_cfg_reg_q[`FCR_ZWS_EN_BIT] & ~func_cfg_reg_q[`FCR_ZWS_DIS_BIT];
    assign epp_req = req & epp_en & is_epp_idx(idx);

    // Only the second stage is read; the first may be metastable.
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            wait_m_q <= 1'b1;
            wait_s_q <= 1'b1;
            pd_m_q   <= 8'h00;
            pd_s_q   <= 8'h00;
        end
        else
        begin
            wait_m_q <= WAIT_N;
            wait_s_q <= wait_m_q;
            pd_m_q   <= PERIPH_DATA_I;
            pd_s_q   <= pd_m_q;
        end
    end

    // Handshake sequencer and the peripheral control lines.
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            state_q    <= ST_IDLE;
            lines_q    <= '{write_n: 1'b1, addr_strobe_n: 1'b1, data_strobe_n: 1'b1};
            sel_addr_q <= 1'b0;
            is_read_q  <= 1'b0;
            saw_low_q  <= 1'b0;
            zws_q      <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    zws_q     <= 1'b0;
                    saw_low_q <= 1'b0;
                    if (epp_req)
                    begin
                        sel_addr_q <= (idx == `IDX_ADDR);
                        is_read_q  <= AVS_READ;
                        if (rev19 && !zws_en)
                            state_q <= AVS_READ ? ST_R19_WAITLO : ST_W19_WAITLO;
                        else if (AVS_WRITE)
                        begin
                            lines_q.write_n <= 1'b0;
                            state_q         <= ST_SETUP;
                        end
                        else
                        begin
                            if (idx == `IDX_ADDR)
                                lines_q.addr_strobe_n <= 1'b0;
                            else
                                lines_q.data_strobe_n <= 1'b0;
                            state_q <= ST_STROBE;
                        end
                    end
                    else if (req)
                        state_q <= ST_ACK;
                end
                ST_SETUP:
                begin
                    // Strobe follows write by a whole cycle so data is settled first.
                    if (sel_addr_q)
                        lines_q.addr_strobe_n <= 1'b0;
                    else
                        lines_q.data_strobe_n <= 1'b0;
                    state_q <= ST_STROBE;
                end
                ST_STROBE:
                begin
                    if (!wait_s_q)
                        saw_low_q <= 1'b1;
                    else if (dwell_q == 2'h3)
                    begin
                        zws_q   <= zws_en & ~saw_low_q;
                        state_q <= ST_ACK;
                    end
                end
                ST_W19_WAITLO:
                begin
                    if (!wait_s_q)
                    begin
                        lines_q.write_n <= 1'b0;
                        if (sel_addr_q)
                            lines_q.addr_strobe_n <= 1'b0;
                        else
                            lines_q.data_strobe_n <= 1'b0;
                        state_q <= ST_STROBE19;
                    end
                end
                ST_R19_WAITLO:
                begin
                    if (!wait_s_q)
                    begin
                        if (sel_addr_q)
                            lines_q.addr_strobe_n <= 1'b0;
                        else
                            lines_q.data_strobe_n <= 1'b0;
                        state_q <= ST_STROBE19;
                    end
                end
                ST_STROBE19:
                begin
                    if (wait_s_q)
                    begin
                        lines_q.addr_strobe_n <= 1'b1;
                        lines_q.data_strobe_n <= 1'b1;
                        state_q               <= ST_ACK;
                    end
                end
                ST_ACK:
                begin
                    if (!epp_en || !is_epp_idx(idx) || (state_q == ST_ACK && !lines_q.write_n && rev19 && !zws_en
                        && is_read_q))
                        state_q <= ST_IDLE;
                    else if (rev19 && !zws_en)
                        state_q <= is_read_q ? ST_IDLE : ST_TAIL19;
                    else
                        state_q <= ST_END17;
                    if (!(rev19 && !zws_en))
                    begin
                        lines_q.write_n       <= 1'b1;
                        lines_q.addr_strobe_n <= 1'b1;
                        lines_q.data_strobe_n <= 1'b1;
                    end
                end
                ST_END17:
                begin
                    state_q <= ST_IDLE;
                end
                ST_TAIL19:
                begin
                    if (port_tweak_reg_q[`PTR_DIRCTL_BIT] && port_ctl_reg_q[`CTL_DIR_BIT])
                    begin
                        lines_q.write_n <= 1'b1;
                        state_q         <= ST_IDLE;
                    end
                    else if (!wait_s_q)
                    begin
                        if (!(AVS_WRITE && epp_en && is_epp_idx(idx)))
                            lines_q.write_n <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // A strobe phase lasts at least four cycles, so the synchronised wait line and data show
    // what the peripheral did after the strobe fell; the price is a longer zero-wait host cycle.
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
            dwell_q <= 2'h0;
        else if (state_q != ST_STROBE)
            dwell_q <= 2'h0;
        else if (dwell_q != 2'h3)
            dwell_q <= dwell_q + 2'h1;
    end

    // Peripheral data latch and its drive enable.
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            pd_out_q <= `DTR_RESET;
            pd_oe_q  <= 1'b1;
        end
        else if (state_q == ST_IDLE && epp_req)
        begin
            if (AVS_WRITE && !(rev19 && !zws_en))
            begin
                pd_out_q <= AVS_WRITEDATA[7:0];
                pd_oe_q  <= 1'b1;
            end
            else if (AVS_READ)
                pd_oe_q <= 1'b0;
        end
        else if (state_q == ST_W19_WAITLO && !wait_s_q)
        begin
            pd_out_q <= AVS_WRITEDATA[7:0];
            pd_oe_q  <= 1'b1;
        end
        else if (state_q == ST_ACK && AVS_WRITE && idx == `IDX_DTR && lines_q.write_n)
        begin
            pd_out_q <= AVS_WRITEDATA[7:0];
            pd_oe_q  <= 1'b1;
        end
    end

    // Software registers, written at the edge that accepts the access, a cycle before it completes.
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            port_ctl_reg_q   <= `CTL_RESET;
            port_cfg_reg_q   <= `PCR_RESET;
            func_cfg_reg_q   <= `FCR_RESET;
            port_tweak_reg_q <= `PTR_RESET;
        end
        else if (state_q == ST_IDLE && req && !epp_req && AVS_WRITE)
        begin
            // Bits 0, 1 and 3 need no clearing before EPP use; while epp_en is set the sequencer drives those lines.
            if (idx == `IDX_CTL)
                port_ctl_reg_q <= AVS_WRITEDATA[7:0];
            if (idx == `IDX_PCR)
                port_cfg_reg_q <= AVS_WRITEDATA[7:0];
            if (idx == `IDX_FCR)
                func_cfg_reg_q <= AVS_WRITEDATA[7:0];
            if (idx == `IDX_PTR)
                port_tweak_reg_q <= AVS_WRITEDATA[7:0];
        end
    end

    // Read data is captured one cycle ahead so the bus sees a flop.
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
            rdata_q <= 8'h00;
        else if (state_q == ST_STROBE && wait_s_q)
            rdata_q <= pd_s_q;
        else if (state_q == ST_STROBE19 && wait_s_q)
            rdata_q <= pd_s_q;
        else if (state_q == ST_IDLE && req && !epp_req)
        begin
            unique case (idx)
                `IDX_DTR: rdata_q <= pd_s_q;
                `IDX_STR: rdata_q <= {~wait_s_q, 7'h00};
                `IDX_CTL: rdata_q <= port_ctl_reg_q | `CTL_RD_ONES;
                `IDX_PCR: rdata_q <= port_cfg_reg_q;
                `IDX_FCR: rdata_q <= func_cfg_reg_q;
                `IDX_PTR: rdata_q <= port_tweak_reg_q;
                default:  rdata_q <= 8'h00;
            endcase
        end
    end

    assign AVS_WAITREQUEST   = (state_q != ST_ACK);
    assign AVS_READDATA      = (state_q == ST_ACK) ? {24'h000000, rdata_q} : 32'h00000000;
    assign IOCHRDY           = ~(((state_q == ST_STROBE || (state_q == ST_SETUP && !zws_en)) && !wait_s_q)
                               || state_q == ST_W19_WAITLO || state_q == ST_R19_WAITLO
                               || state_q == ST_STROBE19);
    assign ZERO_WAIT_GRANT_N = ~(state_q == ST_ACK && zws_q);
    assign PERIPH_DATA_O     = pd_out_q;
    assign PERIPH_DATA_OE    = pd_oe_q;

    // In EPP mode hardware owns the strobe, autofeed and select-in lines; otherwise they follow the control register, as INIT always does.
    assign LEGACY_STROBE_LINE_O   = epp_en ? lines_q.write_n : ~port_ctl_reg_q[`CTL_STB_BIT];
    assign LEGACY_AUTOFEED_LINE_O = epp_en ? lines_q.data_strobe_n : ~port_ctl_reg_q[`CTL_AFD_BIT];
    assign LEGACY_SELECTIN_LINE_O = epp_en ? lines_q.addr_strobe_n : ~port_ctl_reg_q[`CTL_LEGACY_SELECTIN_LINE_BIT];
    assign INIT_LINE_O            = port_ctl_reg_q[`CTL_INIT_BIT];

endmodule // epp_handshake_engine

/* File: testbench/epp_periph_model.sv */
// Behavioural EPP peripheral that answers strobe edges on its wait line.
`timescale 1ns/100ps
module epp_periph_model
(
    input  wire logic       clk,
    input  wire logic       write_n,
    input  wire logic       astb_n,
    input  wire logic       dstb_n,
    input  wire logic [7:0] pd_o,
    input  wire logic       pd_oe,
    input  wire logic [3:0] dly,
    input  wire logic       hold_hi,
    input  wire logic [7:0] rd_byte,
    output logic            wait_n,
    output logic      [7:0] pd_i,
    output logic      [7:0] got_byte,
    output logic            got_addr
);
    logic       strb;
    logic [3:0] cnt_q;
    assign strb = !(astb_n && dstb_n);
    initial
    begin
        {wait_n, pd_i, got_byte, got_addr, cnt_q} = '0;
    end
    // The answer to a strobe lags by dly cycles; a release is answered at once, since a late one
    // would be taken by a 1.7 engine as the acknowledge of the next strobe.
    always @(posedge clk)
    begin
        cnt_q <= (wait_n == strb || hold_hi) ? 4'h0 : cnt_q + 4'h1;
        if (hold_hi)
            wait_n <= 1'b1;
        else if (wait_n != strb && (cnt_q >= dly || !strb))
            wait_n <= strb;
        // A bus nobody drives flips every bit each cycle, so no byte stays on it for two cycles running.
        pd_i <= (strb && !pd_oe) ? rd_byte : ~pd_i;
        if (strb && !write_n && pd_oe)
        begin
            got_byte <= pd_o;
            got_addr <= !astb_n;
        end
    end
endmodule // epp_periph_model

/* File: testbench/epp_handshake_engine_sva.sv */
// Checker on the host and connector handshakes of the EPP engine.
`timescale 1ns/100ps
module epp_engine_chk
    import epp_pkg::*;
(
    input wire logic       CLK_SYS,
    input wire logic       RST,
    input wire logic       AVS_READ,
    input wire logic       AVS_WRITE,
    input wire logic       AVS_WAITREQUEST,
    input wire logic       IOCHRDY,
    input wire logic       ZERO_WAIT_GRANT_N,
    input wire logic [7:0] PERIPH_DATA_O,
    input wire logic       PERIPH_DATA_OE,
    input wire logic       LEGACY_STROBE_LINE_O,
    input wire logic       LEGACY_AUTOFEED_LINE_O,
    input wire logic       LEGACY_SELECTIN_LINE_O
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    logic idle_s;
    assign idle_s = LEGACY_SELECTIN_LINE_O && LEGACY_AUTOFEED_LINE_O;
    data_hold_a: assert property ($changed(PERIPH_DATA_O) |-> $past(idle_s))
        else $error("peripheral data changed under a strobe");
    one_strobe_a: assert property (LEGACY_SELECTIN_LINE_O || LEGACY_AUTOFEED_LINE_O)
        else $error("both strobes low");
    stretch_req_a: assert property (!IOCHRDY |-> AVS_WAITREQUEST && (AVS_READ || AVS_WRITE))
        else $error("ready low outside a pending access");
    grant_ack_a: assert property (!ZERO_WAIT_GRANT_N |-> !AVS_WAITREQUEST && IOCHRDY)
        else $error("grant without unstretched answer");
    grant_drop_a: assert property (!ZERO_WAIT_GRANT_N |=> ZERO_WAIT_GRANT_N)
        else $error("grant held past the access");
    wr_end_a: assert property (!AVS_WAITREQUEST && AVS_WRITE && !idle_s |=> idle_s)
        else $error("strobe not released after write");
    rd_end_a: assert property (!AVS_WAITREQUEST && AVS_READ |=> idle_s)
        else $error("strobe not released after read");
    rd_turn_a: assert property (AVS_READ && !idle_s |-> !PERIPH_DATA_OE)
        else $error("data driven during read strobe");
    wr_order_a: assert property ($fell(idle_s) && AVS_WRITE |-> !LEGACY_STROBE_LINE_O)
        else $error("strobe before write line");
    cover property (!ZERO_WAIT_GRANT_N);
    cover property (!IOCHRDY ##1 IOCHRDY);
    cover property ($fell(LEGACY_AUTOFEED_LINE_O) && AVS_READ);
endmodule // epp_engine_chk
bind epp_handshake_engine epp_engine_chk u_chk (.CLK_SYS(CLK_SYS), .RST(RST), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .IOCHRDY(IOCHRDY),
    .ZERO_WAIT_GRANT_N(ZERO_WAIT_GRANT_N), .PERIPH_DATA_O(PERIPH_DATA_O), .PERIPH_DATA_OE(PERIPH_DATA_OE),
    .LEGACY_STROBE_LINE_O(LEGACY_STROBE_LINE_O), .LEGACY_AUTOFEED_LINE_O(LEGACY_AUTOFEED_LINE_O),
    .LEGACY_SELECTIN_LINE_O(LEGACY_SELECTIN_LINE_O));

/* File: testbench/tb_top.sv */
// Self-checking bench: register accesses driving EPP cycles against a peripheral model.
`timescale 1ns/100ps
module tb_top
    import epp_pkg::*;
;
    logic        clk_sys = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, hold_hi = 1'b0;
    logic [5:0]  address = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0]  dly = 4'h2;
    logic [7:0]  rd_byte = 8'h00, pd_o, pd_i, got_byte, x;
    logic        waitreq, rdy, zwg_n, wait_n, pd_oe, wr_n, dstb_n, astb_n, got_addr, init_o;
    int          error_cnt = 0, samples_checked = 0, lo_n = 0, gr_n = 0, wr_up = 0, s, z;
    always #2.5 clk_sys = ~clk_sys;
    // Counted mid-cycle, so a count is complete when a task returns at the answering edge.
    always @(negedge clk_sys)
    begin
        lo_n <= lo_n + (rdy === 1'b0);
        gr_n <= gr_n + (zwg_n === 1'b0);
    end
    always @(posedge wr_n) wr_up++;
    epp_handshake_engine dut (.CLK_SYS(clk_sys), .RST(rst), .AVS_ADDRESS(address), .AVS_READ(read),
        .AVS_WRITE(write), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
        .IOCHRDY(rdy), .ZERO_WAIT_GRANT_N(zwg_n), .WAIT_N(wait_n), .PERIPH_DATA_I(pd_i),
        .PERIPH_DATA_O(pd_o), .PERIPH_DATA_OE(pd_oe), .LEGACY_STROBE_LINE_O(wr_n),
        .LEGACY_AUTOFEED_LINE_O(dstb_n), .LEGACY_SELECTIN_LINE_O(astb_n), .INIT_LINE_O(init_o));
    epp_periph_model u_per (.clk(clk_sys), .write_n(wr_n), .astb_n(astb_n), .dstb_n(dstb_n),
        .pd_o(pd_o), .pd_oe(pd_oe), .dly(dly), .hold_hi(hold_hi), .rd_byte(rd_byte), .wait_n(wait_n),
        .pd_i(pd_i), .got_byte(got_byte), .got_addr(got_addr));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        @(posedge clk_sys);
        address <= {idx, 2'b00};
        wdata   <= {24'h0, wd};
        read    <= !wr;
        write   <= wr;
        do @(posedge clk_sys); while (waitreq !== 1'b0);
        rd = rdata[7:0];
        read  <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wrr(input logic [3:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, x);
    endtask
    task automatic rdc(input logic [3:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00, x);
        chk(x, exp);
    endtask
    task automatic final_report;
        $display("mismatches %0d comparisons %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic settle(input logic hi);
        hold_hi <= hi;
        repeat (10) @(posedge clk_sys);
        s = lo_n;
        z = gr_n;
    endtask
    initial
    begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        rdc(4'hb, 8'h00);
        rdc(4'h3, 8'h00);
        wrr(4'h2, 8'h24);
        rdc(4'h2, 8'he4);
        chk({7'h0, init_o}, 8'h01);
        wrr(4'h8, 8'h01);
        for (int i = 0; i < 2; i++)
        begin
            dly <= i ? 4'h3 : 4'h0;
            settle(1'b0);
            wrr(4'h3, 8'h5a + 8'(i));
            chk(got_byte, 8'h5a + 8'(i));
            chk({7'h0, got_addr}, 8'h01);
            chk({7'h0, lo_n - s > 1}, 8'h01);
        end
        settle(1'b1);
        rdc(4'h1, 8'h00);
        wrr(4'h3, 8'h66);
        chk({7'h0, lo_n == s && gr_n == z}, 8'h01);
        chk(got_byte, 8'h66);
        settle(1'b0);
        rdc(4'h1, 8'h80);
        rd_byte <= 8'hc3;
        rdc(4'h3, 8'hc3);
        chk({7'h0, lo_n > s}, 8'h01);
        for (int i = 4; i < 8; i++)
        begin
            wrr(4'(i), 8'h10 + 8'(i));
            chk(got_byte, 8'h10 + 8'(i));
            chk({7'h0, got_addr}, 8'h00);
            rd_byte <= 8'h80 + 8'(i);
            rdc(4'(i), 8'h80 + 8'(i));
        end
        wrr(4'h9, 8'h20);
        settle(1'b1);
        wrr(4'h4, 8'h77);
        chk({7'h0, gr_n - z == 1 && lo_n == s}, 8'h01);
        chk(got_byte, 8'h77);
        bus(1'b0, 4'h4, 8'h00, x);
        chk({7'h0, gr_n - z == 2}, 8'h01);
        settle(1'b0);
        wrr(4'h4, 8'h78);
        chk({7'h0, gr_n == z && lo_n > s}, 8'h01);
        wrr(4'h9, 8'h60);
        settle(1'b1);
        wrr(4'h4, 8'h79);
        chk({7'h0, gr_n == z}, 8'h01);
        wrr(4'h9, 8'h00);
        dly <= 4'h1;
        settle(1'b0);
        wrr(4'h8, 8'h03);
        wrr(4'h3, 8'ha5);
        chk(got_byte, 8'ha5);
        chk({7'h0, got_addr}, 8'h01);
        rd_byte <= 8'h3c;
        rdc(4'h4, 8'h3c);
        dly <= 4'h4;
        settle(1'b0);
        s = wr_up;
        wrr(4'h4, 8'h11);
        wrr(4'h4, 8'h22);
        repeat (40) @(posedge clk_sys);
        chk({7'h0, wr_up - s == 1}, 8'h01);
        chk(got_byte, 8'h22);
        final_report;
    end
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        final_report;
    end
endmodule // tb_top
